// >>> pkg/fdsir_pkg.sv
package fdsir_pkg;

	localparam logic [7:0] REG_TORCH_CODE   = 8'h04;
	localparam logic [7:0] REG_FAULT_FLAGS  = 8'h05;
	localparam logic [7:0] REG_ID_SOFTRST   = 8'h06;

	localparam logic [6:0] TORCH_CODE_RST   = 7'h00;
	localparam logic [7:0] FAULT_FLAGS_RST  = 8'h00;
	localparam logic [7:0] RDATA_RST        = 8'h00;

	localparam int FLAG_OVERVOLTAGE         = 7;
	localparam int FLAG_LOW_INPUT_MONITOR   = 6;
	localparam int FLAG_OUTPUT_SHORT        = 5;
	localparam int FLAG_CURRENT_LIMIT       = 4;
	localparam int FLAG_THERMAL_SCALE_BACK  = 3;
	localparam int FLAG_THERMAL_SHUTDOWN    = 2;
	localparam int FLAG_UNDERVOLTAGE        = 1;
	localparam int FLAG_FLASH_TIMEOUT       = 0;

	localparam int IDR_SOFT_RESET_BIT       = 7;
	localparam int IDR_ID_LSB               = 3;
	localparam int IDR_REV_LSB              = 0;

	// Die temperature thresholds in degrees C
	localparam logic [7:0] THERMAL_SHUTDOWN_C   = 8'h96;
	localparam logic [7:0] THERMAL_SCALE_BACK_C = 8'h7D;

endpackage : fdsir_pkg

// >>> logic/fdsir_thermal_guard.sv
`timescale 1ns/1ps
`default_nettype none
module fdsir_thermal_guard
	import fdsir_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       sys_rst,
	input  wire logic [7:0] die_temp_c,
	input  wire logic       scale_back_en,
	output logic            thermal_shutdown_ff,
	output logic            thermal_scale_back_ff
);

	wire tsd_hit;
	wire tsb_hit;

	// Shutdown ignores every setting and the soft reset, so it can never be masked
	assign tsd_hit = (die_temp_c >= THERMAL_SHUTDOWN_C); // [RULE5]
	assign tsb_hit = scale_back_en && (die_temp_c >= THERMAL_SCALE_BACK_C);

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			thermal_shutdown_ff   <= 1'b0;
			thermal_scale_back_ff <= 1'b0;
		end else begin
			thermal_shutdown_ff   <= tsd_hit; // [RULE5]
			thermal_scale_back_ff <= tsb_hit;
		end
	end

	chk_tsd_always_on: assert property (@(posedge clk) disable iff (sys_rst) // [RULE5]
		(die_temp_c >= THERMAL_SHUTDOWN_C) |-> ##1 thermal_shutdown_ff)
		else $error("thermal shutdown missed at high die temperature");

	chk_tsd_release: assert property (@(posedge clk) disable iff (sys_rst) // [RULE5]
		(die_temp_c < THERMAL_SHUTDOWN_C) |-> ##1 !thermal_shutdown_ff)
		else $error("thermal shutdown set below threshold");

endmodule : fdsir_thermal_guard
`default_nettype wire

// >>> logic/fdsir_regs.sv
// How it works
// RULE1 - The low seven bits of the torch register select one of 128 torch currents and bit 7 is reserved.
// RULE2 - The flag register reports each fault cause in its own bit, from overvoltage at bit 7 to flash timeout at bit 0.
// RULE3 - Writing one to bit 7 of the identity register resets the device, writing zero leaves it running.
// RULE4 - The identity register shows a fixed device code in bits 5 to 3 and a fixed revision in bits 2 to 0, bit 6 reserved.
// RULE5 - Thermal shutdown at 150 C is always active and no setting can disable it.
// RULE6 - After a soft reset all registers return to power-on values and the reset bit reads zero.
`timescale 1ns/1ps
`default_nettype none
module fdsir_regs
	import fdsir_pkg::*;
#(
	parameter logic [2:0] DEVICE_ID   = 3'h5, // Arbitrary value
	parameter logic [2:0] SILICON_REV = 3'h2  // Arbitrary value
)(
	input  wire logic       clk,
	input  wire logic       sys_rst,
	input  wire logic [7:0] reg_addr,
	input  wire logic       reg_wr,
	input  wire logic [7:0] reg_wdata,
	input  wire logic       reg_rd,
	input  wire logic [7:0] fault_in,
	input  wire logic [7:0] die_temp_c,
	input  wire logic       scale_back_en,
	output logic      [7:0] reg_rdata_ff,
	output logic      [6:0] torch_code_ff,
	output logic      [7:0] fault_flags_ff,
	output logic            soft_rst_ff,
	output logic            thermal_shutdown_ff
);

	logic       tsb_flag;
	logic [7:0] fault_set;
	logic [7:0] nxt_fault_flags;
	logic [7:0] nxt_rdata;

	wire rst_all;
	wire sel_torch;
	wire sel_flags;
	wire sel_id;
	wire wr_torch;
	wire wr_id;
	wire rd_flags;
	wire wr_soft;
	wire sel_none;

	fdsir_thermal_guard u_guard (
		.clk                   (clk),
		.sys_rst               (sys_rst),
		.die_temp_c            (die_temp_c),
		.scale_back_en         (scale_back_en),
		.thermal_shutdown_ff   (thermal_shutdown_ff),
		.thermal_scale_back_ff (tsb_flag)
	);

	// Soft reset lands one cycle after the write and lasts one cycle
	assign rst_all   = sys_rst || soft_rst_ff; // [RULE6]
	assign sel_torch = (reg_addr == REG_TORCH_CODE);
	assign sel_flags = (reg_addr == REG_FAULT_FLAGS);
	assign sel_id    = (reg_addr == REG_ID_SOFTRST);
	assign wr_torch  = reg_wr && sel_torch;
	assign wr_id     = reg_wr && sel_id;
	assign rd_flags  = reg_rd && sel_flags;
	assign wr_soft   = wr_id && reg_wdata[IDR_SOFT_RESET_BIT]; // [RULE3]
	assign sel_none  = !(sel_torch || sel_flags || sel_id);

	genvar i;
	generate
		for (i = 0; i < 8; i++) begin : g_flag
			// Set wins over the clear-on-read so an event in the read cycle survives
			assign fault_set[i] = fault_in[i]
				|| ((i == FLAG_THERMAL_SHUTDOWN) && thermal_shutdown_ff)
				|| ((i == FLAG_THERMAL_SCALE_BACK) && tsb_flag); // [RULE2]
			assign nxt_fault_flags[i] = fault_set[i] || (fault_flags_ff[i] && !rd_flags); // [RULE2]
		end
	endgenerate

	always_comb begin
		nxt_rdata = RDATA_RST;
		if (sel_torch) begin
			nxt_rdata = {1'b0, torch_code_ff}; // [RULE1]
		end else if (sel_flags) begin
			nxt_rdata = fault_flags_ff; // [RULE2]
		end else if (sel_id) begin
			// Reset bit and bit 6 always read zero
			nxt_rdata = {2'b00, DEVICE_ID, SILICON_REV}; // [RULE4] [RULE6]
		end
	end

	always_ff @(posedge clk) begin
		if (rst_all) begin
			torch_code_ff <= TORCH_CODE_RST; // [RULE6]
		end else if (wr_torch) begin
			torch_code_ff <= reg_wdata[6:0]; // [RULE1]
		end
	end

	always_ff @(posedge clk) begin
		if (rst_all) begin
			fault_flags_ff <= FAULT_FLAGS_RST; // [RULE6]
		end else begin
			fault_flags_ff <= nxt_fault_flags; // [RULE2]
		end
	end

	// Requests in the soft reset cycle are lost, the host waits two cycles
	always_ff @(posedge clk) begin
		if (rst_all) begin
			reg_rdata_ff <= RDATA_RST; // [RULE6]
		end else if (reg_rd) begin
			reg_rdata_ff <= nxt_rdata;
		end
	end

	// Only sys_rst resets it; the !soft_rst_ff term ends the pulse so it is never held longer than one cycle
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			soft_rst_ff <= 1'b0;
		end else begin
			soft_rst_ff <= wr_soft && !soft_rst_ff; // [RULE3]
		end
	end

	chk_torch_write: assert property (@(posedge clk) disable iff (sys_rst) // [RULE1]
		(wr_torch && !soft_rst_ff) |=> (torch_code_ff == $past(reg_wdata[6:0])))
		else $error("torch code not stored");

	chk_torch_rsvd: assert property (@(posedge clk) disable iff (sys_rst) // [RULE1]
		(reg_rd && sel_torch && !soft_rst_ff) |=> (reg_rdata_ff == {1'b0, $past(torch_code_ff)}))
		else $error("torch readback wrong");

	chk_flag_capture: assert property (@(posedge clk) disable iff (sys_rst) // [RULE2]
		(!soft_rst_ff && (fault_in != 8'h00)) |=> ((fault_flags_ff & $past(fault_in)) == $past(fault_in)))
		else $error("fault event lost");

	chk_flag_hold: assert property (@(posedge clk) disable iff (sys_rst) // [RULE2]
		(!soft_rst_ff && !rd_flags) |=> ((fault_flags_ff & $past(fault_flags_ff)) == $past(fault_flags_ff)))
		else $error("fault flag dropped without read");

	chk_swrst_pulse: assert property (@(posedge clk) disable iff (sys_rst) // [RULE3]
		(wr_id && reg_wdata[IDR_SOFT_RESET_BIT] && !soft_rst_ff)
		|=> soft_rst_ff ##1 (!soft_rst_ff && (torch_code_ff == TORCH_CODE_RST)))
		else $error("soft reset sequence wrong");

	chk_swrst_zero: assert property (@(posedge clk) disable iff (sys_rst) // [RULE3]
		(wr_id && !reg_wdata[IDR_SOFT_RESET_BIT]) |=> !soft_rst_ff)
		else $error("soft reset on zero write");

	chk_id_read: assert property (@(posedge clk) disable iff (sys_rst) // [RULE4]
		(reg_rd && sel_id && !soft_rst_ff) |=> (reg_rdata_ff == {2'b00, DEVICE_ID, SILICON_REV}))
		else $error("identity readback wrong");

	chk_tsd_flag: assert property (@(posedge clk) disable iff (sys_rst) // [RULE5]
		(thermal_shutdown_ff && !soft_rst_ff) |=> fault_flags_ff[FLAG_THERMAL_SHUTDOWN])
		else $error("thermal shutdown not flagged");

	// Register bank checks beyond the basic access paths
	chk_soft_single: assert property (@(posedge clk) disable iff (sys_rst) // [RULE3]
		soft_rst_ff |=> !soft_rst_ff)
		else $error("soft reset pulse longer than one cycle");

	chk_soft_source: assert property (@(posedge clk) disable iff (sys_rst) // [RULE3]
		$rose(soft_rst_ff) |-> $past(wr_soft))
		else $error("soft reset without a reset write");

	chk_soft_zero_keep: assert property (@(posedge clk) disable iff (sys_rst) // [RULE3]
		(wr_id && !reg_wdata[IDR_SOFT_RESET_BIT] && !soft_rst_ff) |=> $stable(torch_code_ff))
		else $error("zero write to reset bit disturbed the torch code");

	chk_soft_clears: assert property (@(posedge clk) disable iff (sys_rst) // [RULE6]
		soft_rst_ff |=> ((torch_code_ff == TORCH_CODE_RST) && (fault_flags_ff == FAULT_FLAGS_RST)
			&& (reg_rdata_ff == RDATA_RST)))
		else $error("soft reset left a register set");

	chk_soft_zero_read: assert property (@(posedge clk) disable iff (sys_rst) // [RULE6]
		(reg_rd && sel_id) |=> !reg_rdata_ff[IDR_SOFT_RESET_BIT])
		else $error("reset bit read back as one");

	chk_torch_hold: assert property (@(posedge clk) disable iff (sys_rst) // [RULE1]
		(!wr_torch && !soft_rst_ff) |=> $stable(torch_code_ff))
		else $error("torch code changed without a write");

	chk_torch_bit7: assert property (@(posedge clk) disable iff (sys_rst) // [RULE1]
		(reg_rd && sel_torch && !soft_rst_ff) |=> !reg_rdata_ff[7])
		else $error("torch reserved bit read as one");

	chk_rdata_hold: assert property (@(posedge clk) disable iff (sys_rst) // [RULE1]
		(!reg_rd && !soft_rst_ff) |=> $stable(reg_rdata_ff))
		else $error("read data changed without a read");

	chk_unmapped_rd: assert property (@(posedge clk) disable iff (sys_rst) // [RULE4]
		(reg_rd && sel_none && !soft_rst_ff) |=> (reg_rdata_ff == RDATA_RST))
		else $error("unmapped read not zero");

	chk_flag_readback: assert property (@(posedge clk) disable iff (sys_rst) // [RULE2]
		(reg_rd && sel_flags && !soft_rst_ff) |=> (reg_rdata_ff == $past(fault_flags_ff)))
		else $error("flag readback wrong");

	chk_flag_clear: assert property (@(posedge clk) disable iff (sys_rst) // [RULE2]
		(rd_flags && !soft_rst_ff) |=> ((fault_flags_ff & ~$past(fault_set)) == 8'h00))
		else $error("flag survived a read without an event");

	chk_flag_set_wins: assert property (@(posedge clk) disable iff (sys_rst) // [RULE2]
		(rd_flags && (fault_in != 8'h00) && !soft_rst_ff)
		|=> ((fault_flags_ff & $past(fault_in)) == $past(fault_in)))
		else $error("event lost in the read cycle");

	chk_flag_idle: assert property (@(posedge clk) disable iff (sys_rst) // [RULE2]
		((fault_set == 8'h00) && !soft_rst_ff) |=> ((fault_flags_ff & ~$past(fault_flags_ff)) == 8'h00))
		else $error("flag rose without an event");

	chk_flag_no_write: assert property (@(posedge clk) disable iff (sys_rst) // [RULE2]
		(reg_wr && sel_flags && (fault_set == 8'h00) && !soft_rst_ff) |=> $stable(fault_flags_ff))
		else $error("write changed the flag register");

	chk_tsb_flag: assert property (@(posedge clk) disable iff (sys_rst) // [RULE2]
		(tsb_flag && !soft_rst_ff) |=> fault_flags_ff[FLAG_THERMAL_SCALE_BACK])
		else $error("scale-back not flagged");

	chk_tsd_temp_flag: assert property (@(posedge clk) disable iff (sys_rst) // [RULE5]
		((die_temp_c >= THERMAL_SHUTDOWN_C) ##1 !soft_rst_ff) |=> fault_flags_ff[FLAG_THERMAL_SHUTDOWN])
		else $error("hot die not flagged as shutdown");

endmodule : fdsir_regs
`default_nettype wire

// >>> sim/fdsir_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module fdsir_host_model (
	input  wire logic       clk,
	output logic      [7:0] reg_addr,
	output logic            reg_wr,
	output logic      [7:0] reg_wdata,
	output logic            reg_rd
);
	initial begin
		reg_addr = 8'h00;
		reg_wr = 1'b0;
		reg_wdata = 8'h00;
		reg_rd = 1'b0;
	end
	// One strobe cycle per access; a write of bit 7 to 0x06 is how a reset is forced
	task acc(input logic w, input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = w;
		reg_rd = ~w;
		@(negedge clk);
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_wdata = ~d;
	endtask : acc
endmodule : fdsir_host_model
`default_nettype wire

// >>> sim/fdsir_regs_bench.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin checks_done++; if ((s) !== (e)) begin err_total++; \
	$display("[FAIL] %s exp %h got %h", n, e, s); end end
module fdsir_regs_bench;
	import fdsir_pkg::*;
	logic        clk, sys_rst, scale_back_en, reg_wr, reg_rd, rd_seen;
	logic        soft_rst_ff, thermal_shutdown_ff;
	logic  [7:0] reg_addr, reg_wdata, fault_in, die_temp_c, reg_rdata_ff, fault_flags_ff, v, exp_v;
	logic  [6:0] torch_code_ff;
	logic  [7:0] exp_q[$];
	logic [31:0] seed = 32'hC9D49C2D;
	int          err_total, checks_done;
	fdsir_host_model u_host (.clk(clk), .reg_addr(reg_addr), .reg_wr(reg_wr),
		.reg_wdata(reg_wdata), .reg_rd(reg_rd));
	fdsir_regs u_dut (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
		.reg_wdata(reg_wdata), .reg_rd(reg_rd), .fault_in(fault_in), .die_temp_c(die_temp_c),
		.scale_back_en(scale_back_en), .reg_rdata_ff(reg_rdata_ff),
		.torch_code_ff(torch_code_ff), .fault_flags_ff(fault_flags_ff),
		.soft_rst_ff(soft_rst_ff), .thermal_shutdown_ff(thermal_shutdown_ff));
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	function automatic logic [7:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed[7:0];
	endfunction : xs
	task tick(input int n);
		repeat (n) @(negedge clk);
	endtask : tick
	task rd(input logic [7:0] a, input logic [7:0] e);
		exp_q.push_back(e);
		u_host.acc(1'b0, a, 8'h00);
	endtask : rd
	task report_and_stop();
		$display("checks %0d mismatches %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask : report_and_stop
	// Read data lands one cycle after the strobe, so compare on the next falling edge
	always @(posedge clk) rd_seen <= reg_rd;
	always @(negedge clk) begin
		if (rd_seen === 1'b1) begin
			exp_v = exp_q.pop_front();
			`CHK("rdata", exp_v, reg_rdata_ff)
		end
	end
	initial begin
		#250000;
		err_total++;
		report_and_stop();
	end
	initial begin
		sys_rst = 1'b1;
		scale_back_en = 1'b0;
		fault_in = 8'h00;
		die_temp_c = 8'h19;
		tick(2);
		sys_rst = 1'b0;
		rd(REG_TORCH_CODE, 8'h00);
		rd(REG_ID_SOFTRST, 8'h2A);
		rd(8'h07, 8'h00);
		for (int i = 0; i < 4; i++) begin
			v = (i == 0) ? 8'hFF : xs();
			u_host.acc(1'b1, REG_TORCH_CODE, v);
			`CHK("torch_code", v[6:0], torch_code_ff)
			rd(REG_TORCH_CODE, {1'b0, v[6:0]});
		end
		$display("torch test done");
		u_host.acc(1'b1, REG_FAULT_FLAGS, 8'hFF);
		for (int i = 0; i < 8; i++) begin
			@(negedge clk) fault_in = 8'h01 << i;
			@(negedge clk) fault_in = 8'h00;
			`CHK("fault_flags", 8'h01 << i, fault_flags_ff)
			rd(REG_FAULT_FLAGS, 8'h01 << i);
			rd(REG_FAULT_FLAGS, 8'h00);
		end
		fork
			rd(REG_FAULT_FLAGS, 8'h00);
			begin
				@(negedge clk) fault_in = 8'h10;
				@(negedge clk) fault_in = 8'h00;
			end
		join
		rd(REG_FAULT_FLAGS, 8'h10);
		$display("flag test done");
		scale_back_en = 1'b1;
		die_temp_c = 8'h95;
		tick(3);
		`CHK("shutdown", 1'b0, thermal_shutdown_ff)
		die_temp_c = 8'h96;
		tick(2);
		`CHK("shutdown", 1'b1, thermal_shutdown_ff)
		die_temp_c = 8'h19;
		tick(3);
		rd(REG_FAULT_FLAGS, 8'h0C);
		$display("thermal test done");
		u_host.acc(1'b1, REG_TORCH_CODE, 8'h33);
		@(negedge clk) fault_in = 8'h80;
		@(negedge clk) fault_in = 8'h00;
		`CHK("fault_flags", 8'h80, fault_flags_ff)
		u_host.acc(1'b1, REG_ID_SOFTRST, 8'h80);
		`CHK("soft_rst", 1'b1, soft_rst_ff)
		tick(1);
		`CHK("soft_rst", 1'b0, soft_rst_ff)
		`CHK("torch_code", 7'h00, torch_code_ff)
		`CHK("fault_flags", 8'h00, fault_flags_ff)
		`CHK("rdata", 8'h00, reg_rdata_ff)
		rd(REG_TORCH_CODE, 8'h00);
		u_host.acc(1'b1, REG_ID_SOFTRST, 8'h00);
		`CHK("soft_rst", 1'b0, soft_rst_ff)
		rd(REG_ID_SOFTRST, 8'h2A);
		tick(2);
		`CHK("pending", 32'd0, 32'(exp_q.size()))
		$display("reset test done");
		report_and_stop();
	end
endmodule : fdsir_regs_bench
`default_nettype wire
